// *** verification/testbench.sv ***
// Self-checking bench for the video front end with a video source model.
// Assumes the design answers the bus one cycle after a request.
`timescale 1ns/1ps
`include "vif_params.svh"

module testbench
  import vif_pkg::*;
();
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic gclr_n = 1'b0;
  logic pclr_n = 1'b1;
  logic oclr_n = 1'b1;
  logic sel = 1'b0;
  logic pol = 1'b0;
  logic range_sel = 1'b0;
  logic [29:0] req_pix = 30'h0;
  logic [9:0] req_side = 10'h0;
  logic [29:0] pix;
  logic [9:0] side;
  logic dp, dn, cm, sw_out, locked, wreq;
  vif_pixel_t r_out, g_out, b_out;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, q;
  int edge_cnt;
  int err_count = 0;
  int tests_run = 0;

  always #5 core_clk = ~core_clk;

  vif_video_source i_vif_video_source (.core_clk(core_clk), .sel(sel), .pol(pol),
    .req_pix(req_pix), .req_side(req_side), .diff_clock_pos(dp), .diff_clock_neg(dn),
    .cmos_clock_in(cm), .pix(pix), .side(side), .edge_cnt(edge_cnt));

  vif_frontend i_vif_frontend (.core_clk(core_clk), .resetn(resetn),
    .global_clear_n(gclr_n), .pll_clear_n(pclr_n), .rgb_output_preset_n(oclr_n),
    .diff_clock_pos(dp), .diff_clock_neg(dn), .cmos_clock_in(cm),
    .clock_source_select(sel), .clock_polarity_select(pol), .pll_range_select(range_sel),
    .hsync_in(side[9]), .vsync_in(side[8]), .red_pixel_in(pix[29:20]),
    .green_pixel_in(pix[19:10]), .blue_pixel_in(pix[9:0]), .red_overlay_in(side[7:6]),
    .green_overlay_in(side[5:4]), .blue_overlay_in(side[3:2]), .overlay_switch(side[1]),
    .overlay_mix_control(side[0]), .red_pixel_out(r_out), .green_pixel_out(g_out),
    .blue_pixel_out(b_out), .overlay_switch_out(sw_out), .pll_locked(locked),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(wreq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bound(input logic ok);
    if (!ok) begin
      chk("wait done", 1, 0);
      tally_and_finish();
    end
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    bound(n < 50);
  endtask

  task automatic wait_edges(input int e);
    int k, n;
    k = edge_cnt;
    n = 0;
    while (edge_cnt - k < e && n < 20 * e + 20) begin
      @(posedge core_clk);
      n++;
    end
    bound(edge_cnt - k >= e);
  endtask

  task automatic wait_lock();
    int n;
    n = 0;
    while (locked !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    chk("pll_locked", 1, locked);
    bound(locked === 1'b1);
  endtask

  // Used master edges from launch of new words to the output change
  task automatic latency(input string what, input bit ovl_sw, input int exp);
    int k, n;
    n = 0;
    @(posedge core_clk);
    while ((pix !== req_pix || side !== req_side) && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    k = edge_cnt;
    n = 0;
    while ((ovl_sw ? sw_out !== side[1] : r_out !== pix[29:20]) && n < 600) begin
      @(posedge core_clk);
      n++;
    end
    bound(n < 600);
    chk(what, exp, edge_cnt - k);
    if (!ovl_sw) chk("rgb words", pix, {r_out, g_out, b_out});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk("rgb in reset", 30'h0, {r_out, g_out, b_out});
    chk("waitrequest idle", 1, wreq);
    gclr_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    wait_lock();
    bus(0, `VIF_CTRL_OFFS, 0);
    chk("ctrl reset", `VIF_CTRL_RESET, q);
    bus(1, `VIF_CTRL_OFFS, 32'h00000000);
    bus(1, 4'hC, 32'hFFFFFFFF);
    bus(0, 4'h8, 0);
    chk("unmapped read", 0, q);
    bus(0, `VIF_CTRL_OFFS, 0);
    chk("ctrl after writes", 0, q);
    // Every source and polarity choice, rgb and overlay latency each
    for (int c = 0; c < 4; c++) begin
      sel <= c[1];
      pol <= c[0];
      range_sel <= c[1] ^ c[0];
      req_side <= {c[0], c[1], 8'h00};
      wait_edges(10);
      bus(0, `VIF_STATUS_OFFS, 0);
      chk("status", {1'b1, c[1], c[0], 1'b1, c[1] ^ c[0], c[0], c[1]}, q & 32'h7F);
      req_pix <= {10'h3A0 + c[9:0], 10'h05F + c[9:0], 10'h2C3 + c[9:0]};
      latency("rgb delay", 0, `VIF_RGB_DELAY + 1);
      req_side <= {c[0], c[1], 6'h00, 1'b1, 1'b0};
      latency("overlay delay", 1, `VIF_OVL_DELAY + 1);
    end
    // Overlay replace, then mix
    bus(1, `VIF_CTRL_OFFS, 32'h00000001);
    req_pix <= {10'h100, 10'h200, 10'h300};
    req_side <= 10'b00_10_01_11_1_0;
    wait_edges(40);
    chk("overlay replace", {10'h2AA, 10'h155, 10'h3FF}, {r_out, g_out, b_out});
    req_side <= 10'b00_10_01_11_1_1;
    wait_edges(40);
    chk("overlay mix", {10'h1D5, 10'h1AA, 10'h37F}, {r_out, g_out, b_out});
    bus(1, `VIF_CTRL_OFFS, 32'h00000002);
    wait_edges(3);
    chk("forced preset", {3{`VIF_RGB_PRESET}}, {r_out, g_out, b_out});
    bus(1, `VIF_CTRL_OFFS, 32'h00000000);
    wait_edges(40);
    chk("overlay gated", req_pix, {r_out, g_out, b_out});
    // Separate clears
    oclr_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("rgb preset", {3{`VIF_RGB_PRESET}}, {r_out, g_out, b_out});
    chk("lock kept", 1, locked);
    oclr_n <= 1'b1;
    wait_edges(3);
    chk("rgb back", req_pix, {r_out, g_out, b_out});
    pclr_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("lock cleared", 0, locked);
    chk("rgb kept", req_pix, {r_out, g_out, b_out});
    pclr_n <= 1'b1;
    wait_edges(20);
    chk("lock slow in fast range", 0, locked);
    wait_lock();
    range_sel <= 1'b1;
    pclr_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    pclr_n <= 1'b1;
    wait_edges(20);
    chk("lock quick in slow range", 1, locked);
    gclr_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("rgb global", 30'h0, {r_out, g_out, b_out});
    chk("lock global", 0, locked);
    chk("switch global", 0, sw_out);
    gclr_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    bus(0, `VIF_CTRL_OFFS, 0);
    chk("ctrl after clear", `VIF_CTRL_RESET, q);
    tally_and_finish();
  end
endmodule

// *** verification/vif_video_source.sv ***
// Video source model: free-running master clock, syncs, pixel and overlay words.
// Assumes core_clk oversamples; words change only on the unused master edge.
`timescale 1ns/1ps

module vif_video_source
  import vif_pkg::*;
(
  // Clock and setup
  input wire logic core_clk,
  input wire logic sel,
  input wire logic pol,
  // Requested words: pixels, then {hs, vs, ovl r, g, b, switch, mix}
  input wire logic [29:0] req_pix,
  input wire logic [9:0] req_side,
  // Pins
  output logic diff_clock_pos,
  output logic diff_clock_neg,
  output logic cmos_clock_in,
  output logic [29:0] pix,
  output logic [9:0] side,
  output int edge_cnt
);
  logic mclk;
  int div;

  ////////////////////////////////////////////////////////////////////////////
  // Clock already locked to the syncs; only the chosen path toggles
  assign diff_clock_pos = sel ? 1'b0 : mclk;
  assign diff_clock_neg = sel ? 1'b1 : ~mclk;
  assign cmos_clock_in = sel ? mclk : 1'b0;

  initial begin
    mclk = 1'b0;
    div = 0;
    edge_cnt = 0;
    pix = 30'h0;
    side = 10'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fixed rate, never outside the scaled loop range, even with syncs idle
  always @(posedge core_clk) begin
    div <= (div == 3) ? 0 : div + 1;
    if (div == 3) begin
      mclk <= ~mclk;
      if ((~mclk ^ pol) == 1'b1) begin
        edge_cnt <= edge_cnt + 1;
      end else begin
        // Launch on the opposite edge so words are settled when taken
        pix <= req_pix;
        side <= req_side;
      end
    end
  end
endmodule

// *** verilog/vif_delay_ram.sv ***
// Ring-buffer delay line: read data come out of a register.
// Assumes one clock; advance is a one-cycle enable at the master clock rate.
`timescale 1ns/1ps

module vif_delay_ram
  import vif_pkg::*;
#(
  parameter int WIDTH = 30,
  parameter int DEPTH = 30
) (
  // Clock and clear
  input wire logic core_clk,
  input wire logic clear,
  // Stream
  input wire logic advance,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Refused at elaboration: a ring shorter than two slots cannot delay
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("vif_delay_ram: DEPTH must be at least 2 and WIDTH at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] ptr_r;
  logic [PW-1:0] ptr_nxt;
  logic [WIDTH-1:0] rd_data_r;
  logic [WIDTH-1:0] rd_data_nxt;

  always_comb begin
    ptr_nxt = ptr_r;
    rd_data_nxt = rd_data_r;
    if (clear) begin
      ptr_nxt = '0;
      rd_data_nxt = '0;
    end else if (advance) begin
      rd_data_nxt = mem[ptr_r];
      ptr_nxt = (ptr_r == PW'(DEPTH - 1)) ? '0 : ptr_r + PW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    ptr_r <= ptr_nxt;
    rd_data_r <= rd_data_nxt;
  end

  // Contents need no reset; the owner masks output until the ring is full
  always_ff @(posedge core_clk) begin
    if (advance && !clear) begin
      mem[ptr_r] <= wr_data;
    end
  end

  assign rd_data = rd_data_r;
endmodule

// *** verilog/vif_frontend.sv ***
// Video input front end: clock path selection, clears, phase loop, pixel pipe.
// Assumes core_clk at 100 MHz oversamples the master clock pins and that all
// video pins are asynchronous to it; software reaches status over Avalon-MM.
`timescale 1ns/1ps
`include "vif_params.svh"

module vif_frontend
  import vif_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Clears
  input wire logic global_clear_n,
  input wire logic pll_clear_n,
  input wire logic rgb_output_preset_n,
  // Master clock pins
  input wire logic diff_clock_pos,
  input wire logic diff_clock_neg,
  input wire logic cmos_clock_in,
  input wire logic clock_source_select,
  input wire logic clock_polarity_select,
  input wire logic pll_range_select,
  // Syncs and pixels
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic [9:0] red_pixel_in,
  input wire logic [9:0] green_pixel_in,
  input wire logic [9:0] blue_pixel_in,
  // Overlay
  input wire logic [1:0] red_overlay_in,
  input wire logic [1:0] green_overlay_in,
  input wire logic [1:0] blue_overlay_in,
  input wire logic overlay_switch,
  input wire logic overlay_mix_control,
  // Video out
  output logic [9:0] red_pixel_out,
  output logic [9:0] green_pixel_out,
  output logic [9:0] blue_pixel_out,
  output logic overlay_switch_out,
  output logic pll_locked,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int SW = 49;
  localparam int LW = 6;

  function automatic vif_pixel_t mix10(vif_pixel_t pix, logic [1:0] ovl, logic ys, logic ym);
    vif_pixel_t o;
    o = {ovl, ovl, ovl, ovl, ovl};
    if (!ys) begin
      mix10 = pix;
    end else if (ym) begin
      mix10 = {1'b0, pix[9:1]} + {1'b0, o[9:1]};
    end else begin
      mix10 = o;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [SW-1:0] s1_r, s1_nxt, s2_r, s2_nxt;
  logic lvl_d_r, lvl_d_nxt, raw, lvl, master_en;

  always_comb begin
    s1_nxt = {diff_clock_pos, diff_clock_neg, cmos_clock_in, clock_source_select,
              clock_polarity_select, pll_range_select, global_clear_n, pll_clear_n,
              rgb_output_preset_n, hsync_in, vsync_in, red_pixel_in, green_pixel_in,
              blue_pixel_in, red_overlay_in, green_overlay_in, blue_overlay_in,
              overlay_switch, overlay_mix_control};
    s2_nxt = s1_r;
    lvl_d_nxt = lvl;
    if (!resetn) begin
      s1_nxt = '0;
      s2_nxt = '0;
      lvl_d_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    s1_r <= s1_nxt;
    s2_r <= s2_nxt;
    lvl_d_r <= lvl_d_nxt;
  end

  logic dp_s, dn_s, cm_s, sel_s, pol_s, rng_s, gclr_s, pclr_s, rclr_s, hs_s, vs_s;
  logic [29:0] rgb_s;
  logic [7:0] ovl_s;
  assign {dp_s, dn_s, cm_s, sel_s, pol_s, rng_s, gclr_s, pclr_s, rclr_s, hs_s, vs_s,
          rgb_s, ovl_s} = s2_r;

  // Clock path: source, then polarity; edges found by oversampling
  assign raw = sel_s ? cm_s : (dp_s & ~dn_s);
  assign lvl = raw ^ pol_s;
  assign master_en = lvl & ~lvl_d_r;

  // Clears derived from synchronised pins, so release is clean
  logic [31:0] ctrl_r, ctrl_nxt, rdata_r, rdata_nxt;
  logic glob_rst, pll_rst, rgb_rst;
  assign glob_rst = ~resetn | ~gclr_s;
  assign pll_rst = glob_rst | ~pclr_s;
  assign rgb_rst = glob_rst | ~rclr_s | ctrl_r[`VIF_CTRL_FORCE_PRESET];

  ////////////////////////////////////////////////////////////////////////////
  // Phase loop model: divider by range, lock after a run of feedback ticks
  vif_pll_state_t pst_r, pst_nxt;
  logic div_r, div_nxt, locked_r, locked_nxt;
  logic [LW-1:0] lock_cnt_r, lock_cnt_nxt;
  logic fb_tick;
  assign fb_tick = master_en & (rng_s | div_r);

  always_comb begin
    pst_nxt = pst_r;
    div_nxt = div_r;
    lock_cnt_nxt = lock_cnt_r;
    if (master_en) begin
      div_nxt = rng_s ? 1'b0 : ~div_r;
    end
    case (pst_r)
      VIF_PLL_HOLD: begin
        lock_cnt_nxt = '0;
        pst_nxt = VIF_PLL_ACQ;
      end
      VIF_PLL_ACQ: begin
        if (fb_tick) begin
          lock_cnt_nxt = lock_cnt_r + LW'(1);
          if (lock_cnt_r == LW'(`VIF_PLL_LOCK_TICKS - 1)) begin
            pst_nxt = VIF_PLL_LOCK;
          end
        end
      end
      VIF_PLL_LOCK: pst_nxt = VIF_PLL_LOCK;
      default: pst_nxt = VIF_PLL_HOLD;
    endcase
    if (pll_rst) begin
      pst_nxt = VIF_PLL_HOLD;
      div_nxt = 1'b0;
      lock_cnt_nxt = '0;
    end
    locked_nxt = (pst_nxt == VIF_PLL_LOCK);
  end

  always_ff @(posedge core_clk) begin
    pst_r <= pst_nxt;
    div_r <= div_nxt;
    lock_cnt_r <= lock_cnt_nxt;
    locked_r <= locked_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel pipe: capture and output register one master cycle each, ring the rest
  logic [29:0] in_r, in_nxt, rgb_rd;
  logic [7:0] oin_r, oin_nxt, ovl_rd;
  logic [5:0] fill_r, fill_nxt;
  vif_pixel_t red_r, red_nxt, grn_r, grn_nxt, blu_r, blu_nxt;
  logic osw_r, osw_nxt;
  logic rgb_valid, ovl_valid, mix_on;
  assign rgb_valid = (fill_r == 6'(`VIF_RGB_DELAY));
  assign ovl_valid = (fill_r >= 6'(`VIF_OVL_DELAY));
  assign mix_on = ctrl_r[`VIF_CTRL_MIX_EN] & ovl_rd[1];

  always_comb begin
    in_nxt = in_r;
    oin_nxt = oin_r;
    fill_nxt = fill_r;
    red_nxt = red_r;
    grn_nxt = grn_r;
    blu_nxt = blu_r;
    osw_nxt = osw_r;
    if (master_en) begin
      in_nxt = rgb_s;
      oin_nxt = ovl_s;
      if (!rgb_valid) begin
        fill_nxt = fill_r + 6'h01;
      end
      osw_nxt = ovl_valid & ovl_rd[1];
      red_nxt = mix10(rgb_rd[29:20], ovl_rd[7:6], mix_on, ovl_rd[0]);
      grn_nxt = mix10(rgb_rd[19:10], ovl_rd[5:4], mix_on, ovl_rd[0]);
      blu_nxt = mix10(rgb_rd[9:0], ovl_rd[3:2], mix_on, ovl_rd[0]);
      if (!rgb_valid) begin
        red_nxt = `VIF_RGB_PRESET;
        grn_nxt = `VIF_RGB_PRESET;
        blu_nxt = `VIF_RGB_PRESET;
      end
    end
    if (rgb_rst) begin
      red_nxt = `VIF_RGB_PRESET;
      grn_nxt = `VIF_RGB_PRESET;
      blu_nxt = `VIF_RGB_PRESET;
    end
    if (glob_rst) begin
      in_nxt = '0;
      oin_nxt = '0;
      fill_nxt = '0;
      osw_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    in_r <= in_nxt;
    oin_r <= oin_nxt;
    fill_r <= fill_nxt;
    red_r <= red_nxt;
    grn_r <= grn_nxt;
    blu_r <= blu_nxt;
    osw_r <= osw_nxt;
  end

  // Ring depths leave two stages for capture and output registers
  vif_delay_ram #(.WIDTH(30), .DEPTH(`VIF_RGB_DELAY - 2)) u_rgb_ring (
    .core_clk(core_clk),
    .clear(glob_rst),
    .advance(master_en),
    .wr_data(in_r),
    .rd_data(rgb_rd)
  );

  vif_delay_ram #(.WIDTH(8), .DEPTH(`VIF_OVL_DELAY - 2)) u_ovl_ring (
    .core_clk(core_clk),
    .clear(glob_rst),
    .advance(master_en),
    .wr_data(oin_r),
    .rd_data(ovl_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then answer
  logic wait_r, wait_nxt;

  always_comb begin
    ctrl_nxt = ctrl_r;
    rdata_nxt = rdata_r;
    wait_nxt = ~((avs_read | avs_write) & wait_r);
    if (avs_read && wait_r) begin
      rdata_nxt = 32'h00000000;
      if (avs_address == `VIF_CTRL_OFFS) begin
        rdata_nxt = {30'h00000000, ctrl_r[1:0]};
      end else if (avs_address == `VIF_STATUS_OFFS) begin
        rdata_nxt[`VIF_ST_SRC_SEL] = sel_s;
        rdata_nxt[`VIF_ST_POL_SEL] = pol_s;
        rdata_nxt[`VIF_ST_RANGE_SEL] = rng_s;
        rdata_nxt[`VIF_ST_PLL_LOCK] = locked_r;
        rdata_nxt[`VIF_ST_HSYNC] = hs_s;
        rdata_nxt[`VIF_ST_VSYNC] = vs_s;
        rdata_nxt[`VIF_ST_RGB_VALID] = rgb_valid;
      end
    end
    if (avs_write && !wait_r && avs_address == `VIF_CTRL_OFFS) begin
      ctrl_nxt = {30'h00000000, avs_writedata[1:0]};
    end
    if (glob_rst) begin
      ctrl_nxt = `VIF_CTRL_RESET;
      rdata_nxt = 32'h00000000;
      wait_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    ctrl_r <= ctrl_nxt;
    rdata_r <= rdata_nxt;
    wait_r <= wait_nxt;
  end

  assign red_pixel_out = red_r;
  assign green_pixel_out = grn_r;
  assign blue_pixel_out = blu_r;
  assign overlay_switch_out = osw_r;
  assign pll_locked = locked_r;
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_GLOBAL_CLEAR: assert property (@(posedge core_clk)
    glob_rst |=> (ctrl_r == `VIF_CTRL_RESET) && !locked_r && wait_r && (fill_r == 6'h00))
    else $error("global clear did not initialise state");
  AST_PLL_CLEAR: assert property (@(posedge core_clk) disable iff (glob_rst)
    (!pclr_s && rclr_s) |=> !locked_r && (lock_cnt_r == '0) && $stable(ctrl_r))
    else $error("pll clear reached beyond the loop");
  AST_RGB_PRESET: assert property (@(posedge core_clk)
    rgb_rst |=> (red_r == `VIF_RGB_PRESET) && (grn_r == `VIF_RGB_PRESET)
      && (blu_r == `VIF_RGB_PRESET))
    else $error("colour outputs not preset");
  AST_CLK_SOURCE: assert property (@(posedge core_clk) disable iff (!resetn)
    master_en |-> ((sel_s ? cm_s : (dp_s && !dn_s)) != pol_s) && !lvl_d_r)
    else $error("master edge from wrong clock source");
  AST_CLK_POLARITY: assert property (@(posedge core_clk) disable iff (!resetn)
    (master_en && pol_s) |-> !raw)
    else $error("inverted clock edge taken on wrong level");
  AST_PLL_RANGE: assert property (@(posedge core_clk) disable iff (pll_rst)
    (master_en && !rng_s && !div_r) |-> !fb_tick ##1 (div_r || !$past(master_en)))
    else $error("divider not halving in the fast range");
  AST_PIXEL_CAPTURE: assert property (@(posedge core_clk) disable iff (glob_rst)
    master_en |=> (in_r == $past(rgb_s)) && (oin_r == $past(ovl_s)))
    else $error("pixel words not taken on master edge");
  AST_OVERLAY_MIX: assert property (@(posedge core_clk) disable iff (rgb_rst)
    (master_en && rgb_valid && mix_on && !ovl_rd[0]) |=> red_r == {5{$past(ovl_rd[7:6])}})
    else $error("overlay colour not switched in");
  AST_RGB_DELAY: assert property (@(posedge core_clk) disable iff (glob_rst)
    (master_en && fill_r == 6'(`VIF_RGB_DELAY - 1)) |=> rgb_valid)
    else $error("colour pipe not 32 master cycles");
  AST_OVL_DELAY: assert property (@(posedge core_clk) disable iff (glob_rst)
    (master_en && fill_r == 6'(`VIF_OVL_DELAY - 1)) |=> ovl_valid && !$past(ovl_valid))
    else $error("overlay pipe not 25 master cycles");
  AST_CLEAR_ORDER: assert property (@(posedge core_clk)
    glob_rst |-> pll_rst && rgb_rst)
    else $error("global clear does not dominate");
endmodule

// *** verilog/vif_params.svh ***
// Constants of the video input front end: offsets, fields, reset values, delays.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef VIF_PARAMS_SVH
`define VIF_PARAMS_SVH

// Register byte offsets and control reset value
`define VIF_CTRL_OFFS 4'h0
`define VIF_STATUS_OFFS 4'h4
`define VIF_CTRL_RESET 32'h00000001

// Control fields
`define VIF_CTRL_MIX_EN 0
`define VIF_CTRL_FORCE_PRESET 1

// Status fields
`define VIF_ST_SRC_SEL 0
`define VIF_ST_POL_SEL 1
`define VIF_ST_RANGE_SEL 2
`define VIF_ST_PLL_LOCK 3
`define VIF_ST_HSYNC 4
`define VIF_ST_VSYNC 5
`define VIF_ST_RGB_VALID 6

// Pipeline delays in master clock cycles
`define VIF_RGB_DELAY 32
`define VIF_OVL_DELAY 25

// Preset value shown on every colour output while preset
`define VIF_RGB_PRESET 10'h000

// Feedback ticks counted before the phase loop reports lock
`define VIF_PLL_LOCK_TICKS 16

`endif

// *** verilog/vif_pkg.sv ***
// Types shared by the video input front end.
// Assumes vif_params.svh is on the include path.
`include "vif_params.svh"

package vif_pkg;
  typedef enum logic [1:0] {VIF_PLL_HOLD, VIF_PLL_ACQ, VIF_PLL_LOCK} vif_pll_state_t;
  typedef logic [9:0] vif_pixel_t;
endpackage
